// ===== src/mia_pkg.sv
// constants for the mapper interrupt aggregator: register indices,
// field positions, reset values and timing counts.
// assumes a single 125 MHz register clock and APB byte address = 4*index.
package mia_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // marker silence that declares multiframe loss: two multiframes
  localparam int unsigned LOM_TIME_NS = 1000000;
  localparam int unsigned LOM_CYCLES =
    (LOM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAR_LIMIT = 15;

  localparam int unsigned NUM_TRIBS = 21;
  localparam int unsigned VEC_W = 24;
  localparam int unsigned ALARM_W = 13;
  localparam int unsigned EVT_W = 3;

  localparam logic [5:0] IDX_VERSION = 6'h0a;
  localparam logic [5:0] IDX_CONFIG = 6'h0b;
  localparam logic [5:0] IDX_GLOBAL = 6'h0c;
  localparam logic [5:0] IDX_VEC0 = 6'h0d;
  localparam logic [5:0] IDX_VEC1 = 6'h0e;
  localparam logic [5:0] IDX_VEC2 = 6'h0f;
  localparam logic [5:0] IDX_TRIB_SEL = 6'h10;
  localparam logic [5:0] IDX_TRIB_INTR = 6'h11;
  localparam logic [5:0] IDX_TRIB_STAT = 6'h12;
  localparam logic [5:0] IDX_TRIB_EN = 6'h13;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h14;
  localparam logic [5:0] IDX_EVT_MASK = 6'h15;

  localparam int unsigned CFG_FREEZE_BIT = 3;
  localparam int unsigned CFG_LOM_EN_BIT = 2;
  localparam int unsigned CFG_PAR_EN_BIT = 1;
  localparam int unsigned CFG_MASTER_BIT = 0;
  localparam int unsigned CFG_W = 4;

  localparam int unsigned GLB_LOM_STATE_BIT = 5;
  localparam int unsigned GLB_LOM_IRQ_BIT = 4;
  localparam int unsigned GLB_PAR_IRQ_BIT = 3;
  localparam int unsigned GRP1_LO = 0;
  localparam int unsigned GRP1_HI = 7;
  localparam int unsigned GRP2_LO = 8;
  localparam int unsigned GRP2_HI = 15;
  localparam int unsigned GRP3_LO = 16;
  localparam int unsigned GRP3_HI = 20;

  localparam int unsigned EVT_LOM_BIT = 0;
  localparam int unsigned EVT_PAR_BIT = 1;
  localparam int unsigned EVT_TRIB_BIT = 2;

  localparam logic [CFG_W-1:0] CONFIG_RST = 4'h0;
  localparam logic [ALARM_W-1:0] TRIB_EN_RST = 13'h0000;
  localparam logic [EVT_W-1:0] EVT_MASK_RST = 3'h0;
  localparam logic [4:0] TRIB_SEL_RST = 5'h00;
endpackage

// ===== src/mia_drop_mon.sv
// drop-bus watcher: multiframe start, marker loss and parity mismatches.
// assumes the drop-bus signals are synchronous to pclk.
module mia_drop_mon
  import mia_pkg::*;
#(
  parameter int unsigned LOM_CYCLES_P = LOM_CYCLES,
  parameter bit ODD_PARITY = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] drop_bus_byte,
  input wire logic drop_bus_parity,
  input wire logic drop_bus_valid,
  input wire logic drop_bus_multiframe_marker,
  input wire logic count_restart,
  output logic mf_tick,
  output logic parity_alarm,
  output logic multiframe_loss_state
);
  localparam int CW = $clog2(LOM_CYCLES_P + 1);
  logic marker_q;
  logic [3:0] par_cnt_q;
  logic [CW-1:0] lom_cnt_q;
  logic mf_start;
  logic mismatch;

  assign mf_start = drop_bus_multiframe_marker & ~marker_q;
  assign mismatch = drop_bus_valid &
    ((^drop_bus_byte ^ ODD_PARITY) != drop_bus_parity);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marker_q <= 1'b0;
      mf_tick <= 1'b0;
    end else begin
      marker_q <= drop_bus_multiframe_marker;
      mf_tick <= mf_start;
    end
  end

  // saturating count gives one alarm at most between restarts (multiframe start or global read)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_cnt_q <= 4'h0;
      parity_alarm <= 1'b0;
    end else begin
      parity_alarm <= 1'b0;
      if (mf_start || count_restart) begin
        par_cnt_q <= 4'h0;
      end else if (mismatch && par_cnt_q != 4'(PAR_LIMIT)) begin
        par_cnt_q <= par_cnt_q + 4'h1;
        parity_alarm <= (par_cnt_q == 4'(PAR_LIMIT - 1));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lom_cnt_q <= '0;
      multiframe_loss_state <= 1'b0;
    end else if (drop_bus_multiframe_marker) begin
      lom_cnt_q <= '0;
      multiframe_loss_state <= 1'b0;
    end else if (lom_cnt_q == CW'(LOM_CYCLES_P - 1)) begin
      multiframe_loss_state <= 1'b1;
    end else begin
      lom_cnt_q <= lom_cnt_q + CW'(1);
    end
  end

  lom_state_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    drop_bus_multiframe_marker |=> !multiframe_loss_state)
    else $error("loss state set while marker seen");
  lom_raise_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !drop_bus_multiframe_marker && lom_cnt_q == CW'(LOM_CYCLES_P - 1)
    |=> multiframe_loss_state)
    else $error("loss state not set after marker silence");
  par_count_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    parity_alarm |-> $past(par_cnt_q) == 4'(PAR_LIMIT - 1))
    else $error("parity alarm not on fifteenth mismatch");
  cnt_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    count_restart |=> par_cnt_q == 4'h0)
    else $error("mismatch count not restarted by read");
endmodule

// ===== src/mia_trib_slot.sv
// one tributary's interrupt and status registers with update freeze.
// assumes alarm levels from the tributary detectors, sampled per multiframe.
module mia_trib_slot
  import mia_pkg::*;
#(
  parameter int unsigned AW = ALARM_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [AW-1:0] alarm,
  input wire logic [AW-1:0] enable,
  input wire logic mf_tick,
  input wire logic freeze_en,
  input wire logic status_read,
  output logic [AW-1:0] intr_q,
  output logic [AW-1:0] status_q,
  output logic pending
);
  logic frozen_q;
  logic update;

  assign update = mf_tick & ~(freeze_en & frozen_q);
  assign pending = |(intr_q & enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intr_q <= '0;
      status_q <= '0;
    end else if (update) begin
      intr_q <= alarm;
      status_q <= alarm;
    end
  end

  // a new enabled interrupt beats a status read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frozen_q <= 1'b0;
    end else if (update && freeze_en && |(alarm & enable)) begin
      frozen_q <= 1'b1;
    end else if (status_read) begin
      frozen_q <= 1'b0;
    end
  end

  freeze_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    frozen_q && freeze_en |=> $stable(intr_q) && $stable(status_q))
    else $error("frozen tributary registers changed");
  slot_update_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    mf_tick && !freeze_en
    |=> intr_q == $past(alarm) && status_q == $past(alarm))
    else $error("unfrozen tributary missed its multiframe update");
endmodule

// ===== src/mia_top.sv
// interrupt configuration and aggregation for a 21-tributary mapper,
// with an APB slave for its registers.
// assumes drop-bus and tributary alarm inputs synchronous to pclk.
module mia_top
  import mia_pkg::*;
#(
  parameter int unsigned LOM_CYCLES_P = LOM_CYCLES,
  // arbitrary version value
  parameter logic [7:0] VERSION_CODE = 8'h5a
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] drop_bus_byte,
  input wire logic drop_bus_parity,
  input wire logic drop_bus_valid,
  input wire logic drop_bus_multiframe_marker,
  input wire logic [NUM_TRIBS-1:0][ALARM_W-1:0] trib_alarm,
  output logic int_n,
  output logic irq
);
  logic [CFG_W-1:0] config_q;
  logic [4:0] trib_sel_q;
  logic [ALARM_W-1:0] trib_en_q;
  logic [EVT_W-1:0] evt_status_q;
  logic [EVT_W-1:0] evt_mask_q;
  logic lom_irq_q;
  logic par_irq_q;
  logic lom_state_q;
  logic any_pend_q;

  logic setup;
  logic access;
  logic wr_done;
  logic rd_done;
  logic [5:0] idx;
  logic [31:0] rd_word;
  logic rd_err;
  logic glb_rd;
  logic stat_rd;

  logic mf_tick;
  logic parity_alarm;
  logic lom_state;
  logic lom_set;
  logic any_pend;
  logic [2:0] groups;
  logic [VEC_W-1:0] vector;
  logic [EVT_W-1:0] evt_set;
  logic [NUM_TRIBS-1:0] pend;
  logic [NUM_TRIBS-1:0][ALARM_W-1:0] intr_v;
  logic [NUM_TRIBS-1:0][ALARM_W-1:0] stat_v;
  logic [ALARM_W-1:0] sel_intr;
  logic [ALARM_W-1:0] sel_stat;
  logic sel_ok;

  assign idx = paddr[7:2];
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_done = access & pwrite & ~pslverr;
  assign rd_done = access & ~pwrite & ~pslverr;
  assign glb_rd = rd_done & (idx == IDX_GLOBAL);
  assign stat_rd = rd_done & (idx == IDX_TRIB_STAT);

  mia_drop_mon #(
    .LOM_CYCLES_P(LOM_CYCLES_P),
    .ODD_PARITY(1'b0)
  ) u_drop_mon (
    .pclk(pclk),
    .presetn(presetn),
    .drop_bus_byte(drop_bus_byte),
    .drop_bus_parity(drop_bus_parity),
    .drop_bus_valid(drop_bus_valid),
    .drop_bus_multiframe_marker(drop_bus_multiframe_marker),
    .count_restart(glb_rd),
    .mf_tick(mf_tick),
    .parity_alarm(parity_alarm),
    .multiframe_loss_state(lom_state)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TRIBS; gi++) begin : g_trib
      mia_trib_slot #(
        .AW(ALARM_W)
      ) u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .alarm(trib_alarm[gi]),
        .enable(trib_en_q),
        .mf_tick(mf_tick),
        .freeze_en(config_q[CFG_FREEZE_BIT]),
        .status_read(stat_rd && trib_sel_q == 5'(gi)),
        .intr_q(intr_v[gi]),
        .status_q(stat_v[gi]),
        .pending(pend[gi])
      );
    end
  endgenerate

  assign sel_ok = trib_sel_q < 5'(NUM_TRIBS);
  assign sel_intr = sel_ok ? intr_v[trib_sel_q] : '0;
  assign sel_stat = sel_ok ? stat_v[trib_sel_q] : '0;

  assign vector = {{(VEC_W - NUM_TRIBS){1'b0}}, pend};
  assign groups[2] = |pend[GRP3_HI:GRP3_LO];
  assign groups[1] = |pend[GRP2_HI:GRP2_LO];
  assign groups[0] = |pend[GRP1_HI:GRP1_LO];
  assign any_pend = |pend;
  assign lom_set = lom_state & ~lom_state_q;

  // read data of the addressed word; unmapped or unaligned is an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else begin
      case (idx)
        IDX_VERSION: rd_word[7:0] = VERSION_CODE;
        IDX_CONFIG: rd_word[CFG_W-1:0] = config_q;
        IDX_GLOBAL: begin
          rd_word[GLB_LOM_STATE_BIT] = lom_state_q;
          rd_word[GLB_LOM_IRQ_BIT] = lom_irq_q;
          rd_word[GLB_PAR_IRQ_BIT] = par_irq_q;
          rd_word[2:0] = groups;
        end
        IDX_VEC0: rd_word[7:0] = vector[7:0];
        IDX_VEC1: rd_word[7:0] = vector[15:8];
        IDX_VEC2: rd_word[7:0] = vector[23:16];
        IDX_TRIB_SEL: rd_word[4:0] = trib_sel_q;
        IDX_TRIB_INTR: rd_word[ALARM_W-1:0] = sel_intr;
        IDX_TRIB_STAT: rd_word[ALARM_W-1:0] = sel_stat;
        IDX_TRIB_EN: rd_word[ALARM_W-1:0] = trib_en_q;
        IDX_EVT_STATUS: rd_word[EVT_W-1:0] = evt_status_q;
        IDX_EVT_MASK: rd_word[EVT_W-1:0] = evt_mask_q;
        default: rd_err = 1'b1;
      endcase
    end
  end

  // one wait-free access phase: data are ready when penable rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= rd_err;
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end else if (access) begin
        pslverr <= 1'b0;
      end
    end
  end

  // read-only words quietly ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= CONFIG_RST;
      trib_sel_q <= TRIB_SEL_RST;
      trib_en_q <= TRIB_EN_RST;
      evt_mask_q <= EVT_MASK_RST;
    end else if (wr_done) begin
      case (idx)
        IDX_CONFIG: config_q <= pwdata[CFG_W-1:0];
        IDX_TRIB_SEL: trib_sel_q <= pwdata[4:0];
        IDX_TRIB_EN: trib_en_q <= pwdata[ALARM_W-1:0];
        IDX_EVT_MASK: evt_mask_q <= pwdata[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // a new alarm in the cycle of the clearing read is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lom_state_q <= 1'b0;
      lom_irq_q <= 1'b0;
      par_irq_q <= 1'b0;
    end else begin
      lom_state_q <= lom_state;
      if (lom_set) begin
        lom_irq_q <= 1'b1;
      end else if (glb_rd) begin
        lom_irq_q <= 1'b0;
      end
      if (parity_alarm) begin
        par_irq_q <= 1'b1;
      end else if (glb_rd) begin
        par_irq_q <= 1'b0;
      end
    end
  end

  assign evt_set[EVT_LOM_BIT] = lom_set;
  assign evt_set[EVT_PAR_BIT] = parity_alarm;
  assign evt_set[EVT_TRIB_BIT] = any_pend & ~any_pend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_pend_q <= 1'b0;
      evt_status_q <= '0;
    end else begin
      any_pend_q <= any_pend;
      if (wr_done && idx == IDX_EVT_STATUS) begin
        evt_status_q <= (evt_status_q & ~pwdata[EVT_W-1:0]) | evt_set;
      end else begin
        evt_status_q <= evt_status_q | evt_set;
      end
    end
  end

  // pin is held high through reset so no interrupt leaks out early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      int_n <= ~(config_q[CFG_MASTER_BIT] &
        ((config_q[CFG_LOM_EN_BIT] & lom_irq_q) |
         (config_q[CFG_PAR_EN_BIT] & par_irq_q) |
         any_pend));
      irq <= |(evt_status_q & evt_mask_q);
    end
  end

  int_master_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !config_q[CFG_MASTER_BIT] |=> int_n)
    else $error("interrupt pin low with master enable off");
  lom_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    config_q[CFG_MASTER_BIT] && config_q[CFG_LOM_EN_BIT] && lom_irq_q
    |=> !int_n)
    else $error("enabled loss interrupt did not drive pin");
  par_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    config_q[CFG_MASTER_BIT] && config_q[CFG_PAR_EN_BIT] && par_irq_q
    |=> !int_n)
    else $error("enabled parity interrupt did not drive pin");
  int_release_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !any_pend && !(config_q[CFG_LOM_EN_BIT] && lom_irq_q) &&
    !(config_q[CFG_PAR_EN_BIT] && par_irq_q) |=> int_n)
    else $error("interrupt pin low with nothing pending");
  int_any_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    config_q[CFG_MASTER_BIT] && any_pend |=> !int_n)
    else $error("pending tributary did not drive pin");
  lom_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    lom_set |=> lom_irq_q)
    else $error("loss interrupt not set by alarm");
  lom_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    glb_rd && !lom_set |=> !lom_irq_q)
    else $error("loss interrupt not cleared by read");
  par_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    parity_alarm |=> par_irq_q)
    else $error("parity interrupt not set by alarm");
  par_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    glb_rd && !parity_alarm |=> !par_irq_q)
    else $error("parity interrupt not cleared by read");
  version_ro_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {IDX_VERSION, 2'b00}
    |=> prdata[7:0] == VERSION_CODE)
    else $error("version word read wrong value");
  ro_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && idx != IDX_CONFIG |=> $stable(config_q))
    else $error("write to another word changed config");
  glb_state_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {IDX_GLOBAL, 2'b00}
    |=> prdata[GLB_LOM_STATE_BIT] == $past(lom_state, 2) &&
    prdata[31:6] == 26'h0)
    else $error("loss state or reserved bits read wrong");
  group_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {IDX_GLOBAL, 2'b00}
    |=> prdata[2:0] == $past(groups))
    else $error("group flags do not match pending tributaries");
  vec_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {IDX_VEC0, 2'b00}
    |=> prdata[7:0] == $past(pend[7:0]))
    else $error("low vector byte wrong");
  vec_mid_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {IDX_VEC1, 2'b00}
    |=> prdata[7:0] == $past(pend[15:8]))
    else $error("middle vector byte wrong");
  vec_top_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {IDX_VEC2, 2'b00}
    |=> prdata[7:5] == 3'b000 && prdata[4:0] == $past(pend[20:16]))
    else $error("upper vector byte wrong");
  ready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_unmapped_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && idx > IDX_EVT_MASK |=> pready && pslverr)
    else $error("unmapped word answered without error");
  // events beat a same-cycle clear; irq trails status by one cycle
  evt_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    |evt_set |=> (evt_status_q & $past(evt_set)) == $past(evt_set))
    else $error("event lost from status");
  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    |(evt_status_q & evt_mask_q) |=> irq)
    else $error("unmasked event did not raise irq");
  irq_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(|(evt_status_q & evt_mask_q)) |=> !irq)
    else $error("irq high with no unmasked event");
endmodule

// ===== sim/mia_drop_src.sv
// drop-bus source standing in for the receive telecom bus.
// assumes it shares pclk with the block; n_bad is taken once a multiframe.
module mia_drop_src #(
  parameter int MF_LEN = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [4:0] n_bad,
  output logic [7:0] drop_bus_byte,
  output logic drop_bus_parity,
  output logic drop_bus_valid,
  output logic drop_bus_multiframe_marker
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pos_q;
  logic [4:0] bad_q;
  logic run_q;
  logic flip;

  // the marker slot itself is never corrupted, so counts are exact
  assign flip = (pos_q != 8'h00) && (pos_q <= {3'h0, bad_q});
  assign drop_bus_valid = run_q;
  // marker stays low while stopped so the block sees the loss
  assign drop_bus_multiframe_marker = run_q && (pos_q == 8'h00);
  // even parity, inverted on the n_bad bytes that follow the marker slot of a multiframe
  assign drop_bus_parity = ^drop_bus_byte ^ (run_q && flip);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= 8'h00;
      bad_q <= 5'h00;
      run_q <= 1'b0;
      drop_bus_byte <= 8'h00;
    end else begin
      pos_q <= (pos_q == 8'(MF_LEN - 1)) ? 8'h00 : pos_q + 8'h01;
      if (pos_q == 8'(MF_LEN - 1)) begin
        bad_q <= n_bad;
      end
      run_q <= run;
      // byte keeps moving when idle so stale data is never mistaken
      drop_bus_byte <= drop_bus_byte + 8'h3b;
    end
  end
endmodule

// ===== sim/tb_mia_top.sv
// self-checking bench for the interrupt aggregator over apb.
// assumes the drop-bus source model and a shortened loss timeout.
module tb_mia_top
  import mia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MF = 40;
  localparam int LOMC = 100;
  localparam logic [7:0] VER = 8'h3c; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, exp_g;
  logic err_v, run, int_n, irq, mv, vld;
  logic [4:0] n_bad;
  logic [7:0] byt;
  logic par;
  logic [NUM_TRIBS-1:0][ALARM_W-1:0] trib_alarm;
  logic [NUM_TRIBS-1:0][ALARM_W-1:0] ta;
  logic [20:0] v;
  logic [3:0] tbl [6];
  int err_count, n_checks, cyc;

  mia_top #(.LOM_CYCLES_P(LOMC), .VERSION_CODE(VER)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drop_bus_byte(byt),
    .drop_bus_parity(par), .drop_bus_valid(vld),
    .drop_bus_multiframe_marker(mv), .trib_alarm(trib_alarm),
    .int_n(int_n), .irq(irq));

  mia_drop_src #(.MF_LEN(MF)) src (
    .pclk(pclk), .presetn(presetn), .run(run), .n_bad(n_bad),
    .drop_bus_byte(byt), .drop_bus_parity(par), .drop_bus_valid(vld),
    .drop_bus_multiframe_marker(mv));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits on pready, the timeout cuts a hang short
  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(rd_v, exp);
  endtask

  task automatic pin(input logic exp);
    repeat (3) @(posedge pclk);
    check({31'h0, int_n}, {31'h0, exp});
  endtask

  task automatic waitmf(input int n);
    repeat (n * MF + 4) @(posedge pclk);
  endtask

  task automatic inject(input logic [4:0] n);
    n_bad <= n;
    waitmf(2);
    n_bad <= 5'h00;
    waitmf(2);
  endtask

  function automatic logic [31:0] grp(input logic [20:0] x);
    return {29'h0, |x[20:16], |x[15:8], |x[7:0]};
  endfunction

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b1;
    n_bad = 5'h00;
    trib_alarm = '0;
    presetn = 1'b0;
    tbl = '{4'h3, 4'h2, 4'h1, 4'h5, 4'h4, 4'h1};
    void'($urandom(32'h23d5));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({31'h0, int_n}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rchk(IDX_CONFIG, 32'h0);
    rchk(IDX_GLOBAL, 32'h0);
    xfer(1'b1, IDX_VERSION, 32'hff);
    rchk(IDX_VERSION, {24'h0, VER});
    check({31'h0, err_v}, 32'h0);
    xfer(1'b0, 6'h3f, 32'h0);
    check({31'h0, err_v}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      exp_g = $urandom;
      xfer(1'b1, IDX_CONFIG, exp_g);
      rchk(IDX_CONFIG, exp_g & 32'hf);
    end
    xfer(1'b1, IDX_CONFIG, 32'h3);
    inject(5'd14);
    rchk(IDX_GLOBAL, 32'h0);
    pin(1'b1);
    // parity then loss, each under full, master-off and source-off config
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, IDX_CONFIG, {28'h0, tbl[i]});
      if (i >= 3) begin
        run <= 1'b0;
        repeat (LOMC + 20) @(posedge pclk);
      end else inject(5'd15);
      pin(i % 3 != 0);
      rchk(IDX_GLOBAL, (i >= 3) ? 32'h30 : 32'h08);
      rchk(IDX_GLOBAL, (i >= 3) ? 32'h20 : 32'h00);
      pin(1'b1);
      if (i >= 3) begin
        run <= 1'b1;
        waitmf(2);
        rchk(IDX_GLOBAL, 32'h0);
      end
    end
    rchk(IDX_EVT_STATUS, 32'h3);
    xfer(1'b1, IDX_EVT_STATUS, 32'h7);
    xfer(1'b1, IDX_TRIB_EN, 32'h1fff);
    xfer(1'b1, IDX_CONFIG, 32'h1);
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 21'h1 : (k == 1) ? 21'h1fffff : 21'($urandom);
      for (int t = 0; t < NUM_TRIBS; t++) begin
        ta[t] = v[t] ? 13'($urandom_range(8191, 1)) : 13'h0;
      end
      trib_alarm <= ta;
      waitmf(2);
      rchk(IDX_GLOBAL, grp(v));
      rchk(IDX_VEC0, {24'h0, v[7:0]});
      rchk(IDX_VEC1, {24'h0, v[15:8]});
      rchk(IDX_VEC2, {27'h0, v[20:16]});
      pin(v == 21'h0);
      if (k == 0) begin
        rchk(IDX_EVT_STATUS, 32'h4);
        check({31'h0, irq}, 32'h0);
        xfer(1'b1, IDX_EVT_MASK, 32'h4);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, IDX_EVT_STATUS, 32'h4);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rchk(IDX_EVT_STATUS, 32'h0);
      end
    end
    xfer(1'b1, IDX_VEC2, 32'hff);
    rchk(IDX_VEC2, {27'h0, v[20:16]});
    ta = '0;
    ta[0] = 13'h0001;
    trib_alarm <= ta;
    waitmf(2);
    xfer(1'b1, IDX_CONFIG, 32'h9);
    waitmf(2);
    trib_alarm <= '0;
    waitmf(2);
    rchk(IDX_VEC0, 32'h1);
    xfer(1'b1, IDX_TRIB_SEL, 32'h0);
    rchk(IDX_TRIB_INTR, 32'h1);
    rchk(IDX_TRIB_STAT, 32'h1);
    waitmf(2);
    rchk(IDX_VEC0, 32'h0);
    rchk(IDX_GLOBAL, 32'h0);
    pin(1'b1);
    close_out();
  end
endmodule
